// ==== tcs_ctrl_properties.sv ====
// Concurrent checks on the control set/clear block ports
`timescale 1ns/1ps
module tcs_ctrl_properties #(
    parameter logic [3:0] SYNC_CYCLES = tcs_pkg::SYNC_CYCLES
) (
    input wire logic        core_clk,
    input wire logic        arst_n,
    input wire logic [31:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        timer_tick,
    input wire logic        update_cond,
    input wire logic        wrap_event,
    input wire logic        capture_enable,
    input wire logic        single_run_mode,
    input wire logic        buffer_update_lock,
    input wire logic        sync_busy,
    input wire tcs_pkg::tcs_pulse_t pulses
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    wire logic wr = psel && penable && pready && pwrite && pstrb[0];
    sequence s_wr_set; wr && paddr == 32'h0000_0014; endsequence
    sequence s_wr_clr; wr && paddr == 32'h0000_0010; endsequence
    sequence s_busy_run; sync_busy [*3]; endsequence
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no pready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready held too long");
    property p_busy; (s_wr_set or s_wr_clr) |=> s_busy_run; endproperty
    a_busy: assert property (p_busy) else $error("sync busy too short");
    property p_cmd; |pulses[6:2] |-> $past(timer_tick) && !$past(sync_busy); endproperty
    a_cmd: assert property (p_cmd) else $error("command without tick");
    property p_copy; pulses.buffer_copy == $past(update_cond && (!buffer_update_lock || capture_enable)); endproperty
    a_copy: assert property (p_copy) else $error("buffer copy wrong");
    property p_halt; single_run_mode && wrap_event |=> pulses.counter_halt; endproperty
    a_halt: assert property (p_halt) else $error("no halt on wrap");
    property p_run_on; s_wr_set ##0 pwdata[2] |=> single_run_mode; endproperty
    a_run_on: assert property (p_run_on) else $error("single run not set");
    property p_run_off; s_wr_clr ##0 pwdata[2] |=> !single_run_mode; endproperty
    a_run_off: assert property (p_run_off) else $error("single run not cleared");
endmodule

// ==== tcs_pkg.sv ====
// Constants, types and register map for the timer control set/clear block
package tcs_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] IDX_CLEAR_ALIAS = 8'h04;
    localparam logic [7:0] IDX_SET_ALIAS   = 8'h05;
    localparam logic [7:0] IDX_SYNC_BUSY   = 8'h08;
    localparam logic [9:0] ADDR_CLEAR_ALIAS = {IDX_CLEAR_ALIAS, 2'b00};
    localparam logic [9:0] ADDR_SET_ALIAS   = {IDX_SET_ALIAS, 2'b00};
    localparam logic [9:0] ADDR_SYNC_BUSY   = {IDX_SYNC_BUSY, 2'b00};
    localparam logic [7:0] CTRL_RESET       = 8'h00;
    localparam int         SYNC_BUSY_BIT    = 2;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [2:0] CMD_NONE      = 3'h0;
    localparam logic [2:0] CMD_RETRIGGER = 3'h1;
    localparam logic [2:0] CMD_STOP      = 3'h2;
    localparam logic [2:0] CMD_UPDATE    = 3'h3;
    localparam logic [2:0] CMD_COUNT_READ_SYNC_COMMAND  = 3'h4;
    localparam logic [2:0] CMD_DMA       = 3'h5;
    localparam logic [1:0] RAMP_TOGGLE   = 2'h0;
    localparam logic [1:0] RAMP_FORCE_B  = 2'h1;
    localparam logic [1:0] RAMP_FORCE_A  = 2'h2;
    localparam logic [1:0] RAMP_HOLD     = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam logic [3:0] SYNC_CYCLES = 4'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [3:0] {
        SEL_NONE = 4'b0001,
        SEL_CLR  = 4'b0010,
        SEL_SET  = 4'b0100,
        SEL_BUSY = 4'b1000
    } tcs_sel_t;

    typedef struct packed {
        logic [2:0] cmd;
        logic [1:0] ramp_cmd;
        logic       single_run;
        logic       lock;
        logic       dir;
    } tcs_ctrl_t;

    typedef struct packed {
        logic retrigger;
        logic stop;
        logic force_update;
        logic read_sync;
        logic dma_trigger;
        logic buffer_copy;
        logic counter_halt;
    } tcs_pulse_t;

    typedef struct packed {
        tcs_ctrl_t   ctrl;
        logic        busy;
        logic [3:0]  sync_cnt;
        logic        ramp_flag;
        tcs_pulse_t  pulses;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } tcs_state_t;

endpackage

// ==== tcs_timer_ctrl.sv ====
// Control set/clear alias register block with command crossing and sync busy
`timescale 1ns/1ps
module tcs_timer_ctrl #(
    parameter logic [3:0] SYNC_CYCLES = tcs_pkg::SYNC_CYCLES
) (
    input  wire logic               core_clk,
    input  wire logic               arst_n,
    input  wire logic [31:0]        paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               timer_tick,
    input  wire logic               update_cond,
    input  wire logic               wrap_event,
    input  wire logic               two_ramp_mode,
    input  wire logic               capture_enable,
    output logic                    count_down,
    output logic                    single_run_mode,
    output logic                    buffer_update_lock,
    output logic                    ramp_cycle_flag,
    output logic                    sync_busy,
    output tcs_pkg::tcs_pulse_t     pulses
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic tcs_pkg::tcs_sel_t decode(input logic [31:0] addr);
        tcs_pkg::tcs_sel_t sel;
        sel = tcs_pkg::SEL_NONE;
        if (addr[31:10] == 22'h0)
        begin
            case (addr[9:0])
                tcs_pkg::ADDR_CLEAR_ALIAS: sel = tcs_pkg::SEL_CLR;
                tcs_pkg::ADDR_SET_ALIAS:   sel = tcs_pkg::SEL_SET;
                tcs_pkg::ADDR_SYNC_BUSY:   sel = tcs_pkg::SEL_BUSY;
                default:                   sel = tcs_pkg::SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    tcs_pkg::tcs_state_t state_reg;
    tcs_pkg::tcs_state_t state_next;
    tcs_pkg::tcs_sel_t   setup_sel;
    tcs_pkg::tcs_sel_t   access_sel;
    logic                write_go;
    tcs_pkg::tcs_ctrl_t  wr;

    assign setup_sel  = decode(paddr);
    assign access_sel = decode(paddr);
    assign write_go   = psel && penable && state_reg.pready && pwrite && pstrb[0];
    assign wr         = tcs_pkg::tcs_ctrl_t'(pwdata[7:0]);

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        state_next         = state_reg;
        state_next.pulses  = '0;
        state_next.pready  = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.prdata  = 32'h0000_0000;

        if (state_reg.busy)
        begin
            if (state_reg.sync_cnt <= 4'h1)
            begin
                state_next.busy     = 1'b0;
                state_next.sync_cnt = 4'h0;
            end
            else
            begin
                state_next.sync_cnt = state_reg.sync_cnt - 4'h1;
            end
        end

        if (!state_reg.busy && timer_tick && state_reg.ctrl.cmd != tcs_pkg::CMD_NONE)
        begin
            state_next.ctrl.cmd = tcs_pkg::CMD_NONE;
            case (state_reg.ctrl.cmd)
                tcs_pkg::CMD_RETRIGGER: state_next.pulses.retrigger    = 1'b1;
                tcs_pkg::CMD_STOP:      state_next.pulses.stop         = 1'b1;
                tcs_pkg::CMD_UPDATE:    state_next.pulses.force_update = 1'b1;
                tcs_pkg::CMD_COUNT_READ_SYNC_COMMAND:  state_next.pulses.read_sync    = 1'b1;
                tcs_pkg::CMD_DMA:       state_next.pulses.dma_trigger  = 1'b1;
                default:                state_next.pulses.retrigger    = 1'b0;
            endcase
        end

        state_next.pulses.counter_halt = state_next.pulses.stop
                                         || (state_reg.ctrl.single_run && wrap_event);

        state_next.pulses.buffer_copy = update_cond && (!state_reg.ctrl.lock || capture_enable);

        if (update_cond && two_ramp_mode && !state_reg.busy)
        begin
            case (state_reg.ctrl.ramp_cmd)
                tcs_pkg::RAMP_FORCE_B: state_next.ramp_flag = 1'b1;
                tcs_pkg::RAMP_FORCE_A: state_next.ramp_flag = 1'b0;
                tcs_pkg::RAMP_HOLD:    state_next.ramp_flag = state_reg.ramp_flag;
                default:               state_next.ramp_flag = !state_reg.ramp_flag;
            endcase
            state_next.ctrl.ramp_cmd = tcs_pkg::RAMP_TOGGLE;
        end

        // APB setup phase
        if (psel && !penable)
        begin
            state_next.pready = 1'b1;
            case (setup_sel)
                tcs_pkg::SEL_CLR:  state_next.prdata = {24'h00_0000, state_reg.ctrl};
                tcs_pkg::SEL_SET:  state_next.prdata = {24'h00_0000, state_reg.ctrl};
                tcs_pkg::SEL_BUSY: state_next.prdata[tcs_pkg::SYNC_BUSY_BIT] = state_reg.busy;
                default:           state_next.pslverr = 1'b1;
            endcase
        end

        // Software write wins over hardware clear
        if (write_go)
        begin
            case (access_sel)
                tcs_pkg::SEL_CLR:
                begin
                    if (wr.cmd != tcs_pkg::CMD_NONE)
                    begin
                        state_next.ctrl.cmd = tcs_pkg::CMD_NONE;
                    end
                    if (wr.ramp_cmd != tcs_pkg::RAMP_TOGGLE)
                    begin
                        state_next.ctrl.ramp_cmd = tcs_pkg::RAMP_TOGGLE;
                    end
                    state_next.ctrl.single_run = state_next.ctrl.single_run && !wr.single_run;
                    state_next.ctrl.lock       = state_next.ctrl.lock && !wr.lock;
                    state_next.ctrl.dir        = state_next.ctrl.dir && !wr.dir;
                    state_next.busy     = 1'b1;
                    state_next.sync_cnt = SYNC_CYCLES;
                end
                tcs_pkg::SEL_SET:
                begin
                    if (wr.cmd != tcs_pkg::CMD_NONE)
                    begin
                        state_next.ctrl.cmd = wr.cmd;
                    end
                    if (wr.ramp_cmd != tcs_pkg::RAMP_TOGGLE)
                    begin
                        state_next.ctrl.ramp_cmd = wr.ramp_cmd;
                    end
                    state_next.ctrl.single_run = state_next.ctrl.single_run || wr.single_run;
                    state_next.ctrl.lock       = state_next.ctrl.lock || wr.lock;
                    state_next.ctrl.dir        = state_next.ctrl.dir || wr.dir;
                    state_next.busy     = 1'b1;
                    state_next.sync_cnt = SYNC_CYCLES;
                end
                default:
                begin
                    state_next.busy = state_next.busy;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg      <= '0;
            state_reg.ctrl <= tcs_pkg::tcs_ctrl_t'(tcs_pkg::CTRL_RESET);
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata             = state_reg.prdata;
    assign pready             = state_reg.pready;
    assign pslverr            = state_reg.pslverr;
    assign count_down         = state_reg.ctrl.dir;
    assign single_run_mode    = state_reg.ctrl.single_run;
    assign buffer_update_lock = state_reg.ctrl.lock;
    assign ramp_cycle_flag    = state_reg.ramp_flag;
    assign sync_busy          = state_reg.busy;
    assign pulses             = state_reg.pulses;

endmodule

// ==== tcs_timer_ctrl_tb.sv ====
// Self-checking bench for the control set/clear block
`timescale 1ns/1ps
module tcs_timer_ctrl_tb;
    localparam logic [31:0] A_CLR = 32'h0000_0010;
    localparam logic [31:0] A_SET = 32'h0000_0014;
    logic        core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        timer_tick = 1'b0, update_cond = 1'b0, wrap_event = 1'b0;
    logic        two_ramp_mode = 1'b0, capture_enable = 1'b0, err;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hf;
    logic        pready, pslverr, count_down, single_run_mode, buffer_update_lock, ramp_cycle_flag, sync_busy;
    tcs_pkg::tcs_pulse_t pulses;
    int          fail_count = 0, cmp_count = 0;
    tcs_timer_ctrl dut (.*);
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // Look at the answer mid-cycle, where it has settled
        @(negedge core_clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(negedge core_clk);
            n++;
        end
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        // Transfer completes at this edge, then release
        @(posedge core_clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ev(input logic [2:0] v);
        @(posedge core_clk);
        {timer_tick, update_cond, wrap_event} <= v;
        @(posedge core_clk);
        {timer_tick, update_cond, wrap_event} <= 3'h0;
        #1;
    endtask
    task automatic idle();
        int n;
        n = 0;
        #1;
        while (sync_busy !== 1'b0 && n++ < 20)
            @(posedge core_clk) #1;
        chk("sync_busy", 32'h0, {31'h0, sync_busy});
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        apb(1'b0, A_CLR, 8'h00);
        chk("clr_reset", 32'h0, rd);
        apb(1'b1, A_SET, 8'h07);
        apb(1'b0, 32'h0000_0020, 8'h00);
        chk("busy_reg", 32'h4, rd);
        apb(1'b1, A_SET, 8'h00);
        apb(1'b0, A_CLR, 8'h00);
        chk("clr_view", 32'h7, rd);
        chk("count_down", 32'h1, {31'h0, count_down});
        chk("single_run_mode", 32'h1, {31'h0, single_run_mode});
        chk("buffer_update_lock", 32'h1, {31'h0, buffer_update_lock});
        idle();
        ev(3'h3);
        chk("halt_nocopy", 32'h1, {25'h0, pulses});
        apb(1'b1, A_CLR, 8'h05);
        apb(1'b0, A_SET, 8'h00);
        chk("set_view", 32'h2, rd);
        chk("single_run_off", 32'h0, {31'h0, single_run_mode});
        chk("count_up", 32'h0, {31'h0, count_down});
        capture_enable <= 1'b1;
        ev(3'h2);
        chk("copy_capture", 32'h2, {25'h0, pulses});
        apb(1'b1, A_CLR, 8'h02);
        capture_enable <= 1'b0;
        ev(3'h2);
        chk("copy_open", 32'h2, {25'h0, pulses});
        chk("lock_off", 32'h0, {31'h0, buffer_update_lock});
    endtask
    task automatic t_cmd();
        logic [7:0] c;
        logic [6:0] e;
        for (c = 8'h1; c <= 8'h5; c++)
        begin
            e = (7'h40 >> (c - 8'h1)) | {6'h0, c == 8'h2};
            apb(1'b1, A_SET, c << 5);
            idle();
            apb(1'b0, A_SET, 8'h00);
            chk("cmd_pending", {24'h0, c << 5}, rd);
            ev(3'h4);
            chk("cmd_pulse", {25'h0, e}, {25'h0, pulses});
            apb(1'b0, A_SET, 8'h00);
            chk("cmd_done", 32'h0, rd);
        end
    endtask
    task automatic t_cancel();
        apb(1'b1, A_SET, 8'h28);
        ev(3'h4);
        chk("busy_hold", 32'h0, {25'h0, pulses});
        apb(1'b1, A_CLR, 8'hf8);
        idle();
        ev(3'h4);
        chk("cancel_pulse", 32'h0, {25'h0, pulses});
        apb(1'b0, A_SET, 8'h00);
        chk("cancel_read", 32'h0, rd);
    endtask
    task automatic t_ramp();
        logic [1:0] k;
        logic       f;
        f = 1'b0;
        two_ramp_mode <= 1'b1;
        for (int i = 1; i < 5; i++)
        begin
            k = 2'(i);
            apb(1'b1, A_SET, {3'h0, k, 3'h0});
            idle();
            ev(3'h2);
            f = (k == 2'h1) ? 1'b1 : (k == 2'h2) ? 1'b0 : (k == 2'h3) ? f : !f;
            chk("ramp_flag", {31'h0, f}, {31'h0, ramp_cycle_flag});
            apb(1'b0, A_SET, 8'h00);
            chk("ramp_clear", 32'h0, rd);
        end
        two_ramp_mode <= 1'b0;
    endtask
    // ****************************************
    // Run
    // ****************************************
    initial
        forever #5 core_clk = ~core_clk;
    initial
    begin
        #100000;
        fail_count++;
        stop_test();
    end
    initial
    begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        t_regs();
        t_cmd();
        t_cancel();
        t_ramp();
        apb(1'b0, 32'h0000_0030, 8'h00);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        stop_test();
    end
endmodule
bind tcs_timer_ctrl tcs_ctrl_properties #(.SYNC_CYCLES(SYNC_CYCLES)) u_chk (.*);
